// >>> virqc_map.svh
// Offsets, field positions, vectors and counts of the interrupt controller.
// Included by the controller; holds definitions only.
`ifndef VIRQC_MAP_SVH
`define VIRQC_MAP_SVH

// ==========================================================
// Register offsets (4-bit register port)
`define VIRQC_OFS_CTRL 4'h0
`define VIRQC_OFS_EF0 4'h1
`define VIRQC_OFS_EF1 4'h2
`define VIRQC_OFS_EF2 4'h3
`define VIRQC_OFS_IL0 4'h4
`define VIRQC_OFS_IL1 4'h5
`define VIRQC_OFS_IL2 4'h6
`define VIRQC_OFS_STAT 4'h7
`define VIRQC_OFS_TBSEL 4'h8

// ==========================================================
// Control register bits
`define VIRQC_CTRL_IMF 0
`define VIRQC_CTRL_WDT_OUT 1
`define VIRQC_CTRL_TRAP_OUT 2
`define VIRQC_CTRL_TBEN 3
`define VIRQC_CTRL_RST 8'h06

// ==========================================================
// Source numbers
`define VIRQC_SRC_TRAP 2
`define VIRQC_SRC_WDT 3
`define VIRQC_SRC_FIRST 4
`define VIRQC_SRC_TBT 7
`define VIRQC_SRC_LAST 23
`define VIRQC_SRC_BANK 16
`define VIRQC_PROTECT 24'h00_000C
`define VIRQC_EXT_MASK 24'h20_2150

// ==========================================================
// Vectors
`define VIRQC_VEC_UNDEF 16'hFFFC
`define VIRQC_VEC_TRAP 16'hFFFA
`define VIRQC_VEC_WDT 16'hFFF8
`define VIRQC_VEC_LOW_BASE 16'hFFF6
`define VIRQC_VEC_HIGH_BASE 16'hFFBE

// ==========================================================
// Acceptance timing in machine cycles (one clock each)
`define VIRQC_ACC_CYCLES 4'h8
`define VIRQC_PUSH_PSW 4'h1
`define VIRQC_PUSH_PCH 4'h2
`define VIRQC_PUSH_PCL 4'h3
`define VIRQC_LOAD_VEC 4'h7

`endif

// >>> virqc_pkg.sv
// Types shared by the interrupt controller files.
// Assumes nothing of its surroundings.
package virqc_pkg;

  // ==========================================================
  // Controller state, one-hot
  typedef enum logic [2:0] {
    VIRQC_RUN = 3'b001,
    VIRQC_ACCEPT = 3'b010,
    VIRQC_LIGHT_IDLE = 3'b100
  } virqc_state_type;

  typedef logic [4:0] virqc_src_type;

endpackage

// >>> virqc_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output changes once stages 2
// and 3 agree.
`timescale 1ns/1ns
module virqc_sync
  import virqc_pkg::*;
#(
  parameter int W = 6,
  parameter logic [5:0] RESET_VAL = 6'h3F
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // ==========================================================
  // Filter: stage 1 feeds only stage 2
  always_comb
  begin
    out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  end

  // Chain registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= RESET_VAL[W-1:0];
      s2_q <= RESET_VAL[W-1:0];
      s3_q <= RESET_VAL[W-1:0];
      out_q <= RESET_VAL[W-1:0];
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

// >>> virqc_top.sv
// Vectored interrupt latch controller for an 8-bit core.
// Assumes a CPU that flags instruction ends, the low-power entry and the
// interrupt return; external pins are asynchronous and active low.
//
// Notes on behaviour
// R1: Twenty-four sources: five pins, nineteen internal.
// R2: Each source has latch and vector.
// R3: Maskable needs master and own enable.
// R4: Fixed hardware priority, lowest level 23.
// R5: Non-maskables share level two, beat maskables.
// R6: Undefined op is non-maskable, vector FFFCH.
// R7: Sources 4..23: flag n, latch n, vectors.
// R8: First serial uses flag/latch 10, FFEAH.
// R9: Second serial uses flag/latch 11, FFE8H.
// R10: Watchdog requests reset until select cleared.
// R11: Address trap requests reset until cleared.
// R12: Timebase edge resumes idle when product zero.
// R13: Timebase edge wakes and services when one.
// R14: Wake timed after synchronising, may come late.
// R15: Pending watchdog blocks idle entry.
// R16: Eight-cycle acceptance, clear, push three, vector.
// R17: Reset clears latches and all enables.
// R18: Software clears latches except 2, 3.
// R19: Return restores saved master enable.
// R20: Non-maskable order: watchdog, trap, undefined, soft.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "virqc_map.svh"
module virqc_top
  import virqc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sources
  input wire logic [4:0] ext_irq_n,
  input wire logic [23:4] int_req,
  input wire logic watchdog_event,
  input wire logic addr_trap_event,
  input wire logic undefined_op_irq,
  input wire logic soft_irq,
  // Time base taps
  input wire logic [7:0] timebase_taps,
  // CPU side
  input wire logic instr_done,
  input wire logic enter_light_idle,
  input wire logic maskable_return_op,
  input wire logic stacked_imf,
  input wire logic [7:0] status_word,
  input wire logic [15:0] pc,
  // Acceptance outputs
  output logic accepting,
  output logic push_we,
  output logic [7:0] push_data,
  output logic sp_dec3,
  output logic vector_load,
  output logic [15:0] vector,
  // Mode and reset request outputs
  output logic light_idle,
  output logic resume,
  output logic wdt_reset_req,
  output logic trap_reset_req,
  output logic master_irq_enable
);

  // ==========================================================
  // Vector of maskable source n; the table jumps after source 15
  function automatic logic [15:0] vec_of(input logic [4:0] n);
    logic [15:0] off;
    off = 16'h0000;
    if (n < 5'(`VIRQC_SRC_BANK))
    begin
      off = {10'h000, n - 5'(`VIRQC_SRC_FIRST), 1'b0};
      vec_of = `VIRQC_VEC_LOW_BASE - off;
    end
    else
    begin
      off = {10'h000, n - 5'(`VIRQC_SRC_BANK), 1'b0};
      vec_of = `VIRQC_VEC_HIGH_BASE - off;
    end
  endfunction

  // ==========================================================
  // State
  virqc_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [23:0] lat_q, lat_d;
  logic [23:0] ef_q, ef_d;
  logic imf_q, imf_d;
  logic wdt_out_q, wdt_out_d;
  logic trap_out_q, trap_out_d;
  logic tben_q, tben_d;
  logic [2:0] tbsel_q, tbsel_d;
  logic undef_q, undef_d;
  logic soft_q, soft_d;
  logic saved_imf_q, saved_imf_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] vec_q, vec_d;
  logic [7:0] rdata_q, rdata_d;
  logic push_we_q, push_we_d;
  logic [7:0] push_q, push_d;
  logic sp3_q, sp3_d;
  logic vld_q, vld_d;
  logic resume_q, resume_d;
  logic wrr_q, wrr_d;
  logic trr_q, trr_d;
  logic [5:0] pins_s;
  logic [4:0] ext_prev_q;
  logic tb_prev_q;

  // Synchronise pins and the selected time-base tap together
  virqc_sync #(.W(6), .RESET_VAL(6'h3F)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({timebase_taps[tbsel_q], ext_irq_n}),
    .sync_out(pins_s)
  );

  // ==========================================================
  // Source events
  logic [23:0] set_vec;
  logic [4:0] ext_fall;
  logic tb_fall;
  always_comb
  begin
    ext_fall = ext_prev_q & ~pins_s[4:0];
    tb_fall = tb_prev_q & ~pins_s[5];
    set_vec = {int_req, 4'h0} & ~`VIRQC_EXT_MASK; // R1
    set_vec[4] = ext_fall[0]; // R1
    set_vec[6] = ext_fall[1];
    set_vec[8] = ext_fall[2];
    set_vec[13] = ext_fall[3];
    set_vec[21] = ext_fall[4];
    set_vec[`VIRQC_SRC_WDT] = watchdog_event & ~wdt_out_q; // R10
    set_vec[`VIRQC_SRC_TRAP] = addr_trap_event & ~trap_out_q; // R11
  end

  // ==========================================================
  // Priority pick: non-maskables first in fixed order, then lowest n
  logic [23:0] elig;
  logic pick_any;
  logic [4:0] pick_n;
  logic pick_undef;
  logic pick_soft;
  logic [15:0] pick_vec;
  always_comb
  begin
    elig = lat_q & ef_q & {24{imf_q}}; // R3
    elig[`VIRQC_SRC_WDT] = lat_q[`VIRQC_SRC_WDT]; // R5
    elig[`VIRQC_SRC_TRAP] = lat_q[`VIRQC_SRC_TRAP];
    pick_any = 1'b1;
    pick_n = 5'h00;
    pick_undef = 1'b0;
    pick_soft = 1'b0;
    pick_vec = `VIRQC_VEC_UNDEF; // R6
    if (elig[`VIRQC_SRC_WDT]) // R20
    begin
      pick_n = 5'(`VIRQC_SRC_WDT);
      pick_vec = `VIRQC_VEC_WDT;
    end
    else if (elig[`VIRQC_SRC_TRAP]) // R20
    begin
      pick_n = 5'(`VIRQC_SRC_TRAP);
      pick_vec = `VIRQC_VEC_TRAP;
    end
    else if (undef_q) // R20
      pick_undef = 1'b1;
    else if (soft_q) // R20
      pick_soft = 1'b1;
    else
    begin
      pick_any = 1'b0;
      // Downward loop leaves the lowest number, the highest rank
      for (int i = `VIRQC_SRC_LAST; i >= `VIRQC_SRC_FIRST; i--) // R4
      begin
        if (elig[i])
        begin
          pick_any = 1'b1;
          pick_n = 5'(i);
        end
      end
      pick_vec = vec_of(pick_n); // R7 R8 R9
    end
  end

  // ==========================================================
  // Control state machine, latches and register writes
  logic tb_product;
  logic acc_start;
  logic tb_take;
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    lat_d = lat_q | set_vec; // R2
    ef_d = ef_q;
    imf_d = imf_q;
    wdt_out_d = wdt_out_q;
    trap_out_d = trap_out_q;
    tben_d = tben_q;
    tbsel_d = tbsel_q;
    undef_d = undef_q | undefined_op_irq;
    soft_d = soft_q | soft_irq;
    saved_imf_d = saved_imf_q;
    pc_d = pc_q;
    vec_d = vec_q;
    push_we_d = 1'b0;
    push_d = push_q;
    sp3_d = 1'b0;
    vld_d = 1'b0;
    resume_d = 1'b0;
    wrr_d = watchdog_event & wdt_out_q; // R10
    trr_d = addr_trap_event & trap_out_q; // R11
    tb_product = imf_q & ef_q[`VIRQC_SRC_TBT] & tben_q;
    acc_start = 1'b0;
    tb_take = 1'b0;
    // Software writes; a clear never wins over a fresh set
    if (reg_wr)
    begin
      unique case (reg_addr)
        `VIRQC_OFS_CTRL:
        begin
          imf_d = reg_wdata[`VIRQC_CTRL_IMF];
          wdt_out_d = reg_wdata[`VIRQC_CTRL_WDT_OUT];
          trap_out_d = reg_wdata[`VIRQC_CTRL_TRAP_OUT];
          tben_d = reg_wdata[`VIRQC_CTRL_TBEN];
        end
        `VIRQC_OFS_EF0: ef_d[7:4] = reg_wdata[7:4]; // R7
        `VIRQC_OFS_EF1: ef_d[15:8] = reg_wdata;
        `VIRQC_OFS_EF2: ef_d[23:16] = reg_wdata;
        `VIRQC_OFS_IL0: // R18
          lat_d[7:0] = (lat_q[7:0] & (reg_wdata | 8'(`VIRQC_PROTECT)))
            | set_vec[7:0];
        `VIRQC_OFS_IL1: lat_d[15:8] = (lat_q[15:8] & reg_wdata)
          | set_vec[15:8];
        `VIRQC_OFS_IL2: lat_d[23:16] = (lat_q[23:16] & reg_wdata)
          | set_vec[23:16];
        `VIRQC_OFS_TBSEL: tbsel_d = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (maskable_return_op)
      imf_d = stacked_imf; // R19
    unique case (st_q)
      VIRQC_RUN:
      begin
        if (instr_done && pick_any)
          acc_start = 1'b1; // R16
        else if (enter_light_idle && !lat_q[`VIRQC_SRC_WDT]
          && !set_vec[`VIRQC_SRC_WDT])
          st_d = VIRQC_LIGHT_IDLE; // R15
      end
      VIRQC_LIGHT_IDLE:
      begin
        // Edge seen after synchronising, so wake may come late
        if (tb_fall) // R14
        begin
          if (tb_product)
          begin
            acc_start = 1'b1; // R13
            tb_take = 1'b1;
          end
          else
          begin
            st_d = VIRQC_RUN; // R12
            resume_d = 1'b1;
          end
        end
      end
      VIRQC_ACCEPT:
      begin
        cnt_d = cnt_q + 4'h1;
        push_we_d = (cnt_q == `VIRQC_PUSH_PSW) ||
          (cnt_q == `VIRQC_PUSH_PCH) || (cnt_q == `VIRQC_PUSH_PCL);
        if (cnt_q == `VIRQC_PUSH_PSW) // R16
          push_d = {status_word[7:1], saved_imf_q};
        if (cnt_q == `VIRQC_PUSH_PCH)
          push_d = pc_q[15:8];
        if (cnt_q == `VIRQC_PUSH_PCL)
        begin
          push_d = pc_q[7:0];
          sp3_d = 1'b1;
        end
        if (cnt_q == `VIRQC_LOAD_VEC)
          vld_d = 1'b1;
        if (cnt_q == `VIRQC_ACC_CYCLES - 4'h1)
          st_d = VIRQC_RUN;
      end
      default: st_d = VIRQC_RUN;
    endcase
    // Acceptance clears master enable and the taken latch
    if (acc_start)
    begin
      st_d = VIRQC_ACCEPT;
      cnt_d = 4'h1;
      saved_imf_d = imf_q;
      imf_d = 1'b0; // R16
      pc_d = pc;
      // Time-base wake bypasses the priority pick, which has one driver
      vec_d = tb_take ? vec_of(5'(`VIRQC_SRC_TBT)) : pick_vec; // R13
      if (tb_take)
        lat_d[`VIRQC_SRC_TBT] = set_vec[`VIRQC_SRC_TBT];
      else if (pick_undef)
        undef_d = undefined_op_irq;
      else if (pick_soft)
        soft_d = soft_irq;
      else
        lat_d[pick_n] = set_vec[pick_n];
    end
  end

  // Register the control state; reset clears every latch and enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= VIRQC_RUN;
      cnt_q <= 4'h0;
      lat_q <= 24'h00_0000; // R17
      ef_q <= 24'h00_0000; // R17
      imf_q <= 1'b0; // R17
      wdt_out_q <= 1'b1; // R10
      trap_out_q <= 1'b1; // R11
      tben_q <= 1'b0;
      tbsel_q <= 3'h0;
      undef_q <= 1'b0;
      soft_q <= 1'b0;
      saved_imf_q <= 1'b0;
      pc_q <= 16'h0000;
      vec_q <= 16'h0000;
      push_we_q <= 1'b0;
      push_q <= 8'h00;
      sp3_q <= 1'b0;
      vld_q <= 1'b0;
      resume_q <= 1'b0;
      wrr_q <= 1'b0;
      trr_q <= 1'b0;
      ext_prev_q <= 5'h1F;
      tb_prev_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lat_q <= lat_d;
      ef_q <= ef_d;
      imf_q <= imf_d;
      wdt_out_q <= wdt_out_d;
      trap_out_q <= trap_out_d;
      tben_q <= tben_d;
      tbsel_q <= tbsel_d;
      undef_q <= undef_d;
      soft_q <= soft_d;
      saved_imf_q <= saved_imf_d;
      pc_q <= pc_d;
      vec_q <= vec_d;
      push_we_q <= push_we_d;
      push_q <= push_d;
      sp3_q <= sp3_d;
      vld_q <= vld_d;
      resume_q <= resume_d;
      wrr_q <= wrr_d;
      trr_q <= trr_d;
      ext_prev_q <= pins_s[4:0];
      tb_prev_q <= pins_s[5];
    end
  end

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `VIRQC_OFS_CTRL: rdata_d = {4'h0, tben_q, trap_out_q,
          wdt_out_q, imf_q};
        `VIRQC_OFS_EF0: rdata_d = {ef_q[7:4], 4'h0};
        `VIRQC_OFS_EF1: rdata_d = ef_q[15:8];
        `VIRQC_OFS_EF2: rdata_d = ef_q[23:16];
        `VIRQC_OFS_IL0: rdata_d = lat_q[7:0]; // R18
        `VIRQC_OFS_IL1: rdata_d = lat_q[15:8];
        `VIRQC_OFS_IL2: rdata_d = lat_q[23:16];
        `VIRQC_OFS_STAT: rdata_d = {3'h0, soft_q, undef_q, st_q};
        `VIRQC_OFS_TBSEL: rdata_d = {5'h00, tbsel_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign accepting = st_q[1];
  assign push_we = push_we_q;
  assign push_data = push_q;
  assign sp_dec3 = sp3_q;
  assign vector_load = vld_q;
  assign vector = vec_q;
  assign light_idle = st_q[2];
  assign resume = resume_q;
  assign wdt_reset_req = wrr_q;
  assign trap_reset_req = trr_q;
  assign master_irq_enable = imf_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_start;
    (st_q == VIRQC_RUN || st_q == VIRQC_LIGHT_IDLE) && acc_start;
  endsequence
  sequence s_pushes;
    push_we_q [*3] ##1 !push_we_q;
  endsequence

  a_accept_len: assert property (s_start |-> ##8 vector_load) // R16
    else $error("vector not loaded eight cycles after accept");
  a_push_order: assert property (s_start |-> ##2 s_pushes) // R16
    else $error("push sequence wrong");
  a_sp_dec: assert property (sp_dec3 |-> $past(push_we_q)) // R16
    else $error("stack pointer step without push");
  a_imf_clear: assert property (s_start |=> !imf_q) // R16
    else $error("master enable not cleared on accept");
  a_mask_gate: assert property (acc_start && st_q == VIRQC_RUN
    && pick_n >= 5'(`VIRQC_SRC_FIRST) |-> imf_q && ef_q[pick_n]) // R3
    else $error("maskable taken while disabled");
  a_wdt_first: assert property (acc_start && lat_q[3] |=>
    vec_q == `VIRQC_VEC_WDT) // R20
    else $error("watchdog not first");
  a_wdt_reset: assert property (watchdog_event && wdt_out_q |=>
    wdt_reset_req && !lat_q[3]) // R10
    else $error("watchdog reset request missing");
  a_idle_block: assert property (st_q == VIRQC_RUN && lat_q[3]
    |=> st_q != VIRQC_LIGHT_IDLE) // R15
    else $error("idle entered with watchdog pending");
  a_wake_plain: assert property (st_q == VIRQC_LIGHT_IDLE && tb_fall
    && !tb_product |=> resume && st_q == VIRQC_RUN) // R12
    else $error("plain wake missing");
  a_ret_restore: assert property (maskable_return_op && !acc_start
    |=> imf_q == $past(stacked_imf)) // R19
    else $error("return did not restore master enable");

endmodule

// >>> virqc_cpu_model.sv
// CPU core model: retires one instruction a cycle while enabled and keeps
// what the controller pushes. Assumes one clk and rst shared with it.
`timescale 1ns/1ns
module virqc_cpu_model
  import virqc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic run_en,
  input wire logic ret_req,
  // Controller side
  input wire logic accepting,
  input wire logic push_we,
  input wire logic [7:0] push_data,
  input wire logic sp_dec3,
  output logic instr_done,
  output logic maskable_return_op,
  output logic stacked_imf,
  output logic [7:0] status_word,
  output logic [15:0] pc,
  // What landed on the stack
  output logic [23:0] stack_q,
  output logic [7:0] sp_q
);
  // ==========================================================
  // Fixed core state; bit 0 low so a pushed 1 can only be the MASTER_IRQ_ENABLE copy
  assign status_word = 8'hA4;
  assign pc = 16'h3C5A;

  // ==========================================================
  // Boundaries, stack and return; the popped MASTER_IRQ_ENABLE is the one pushed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      instr_done <= 1'b0;
      maskable_return_op <= 1'b0;
      stacked_imf <= 1'b0;
      stack_q <= 24'h00_0000;
      sp_q <= 8'hF0;
    end
    else
    begin
      instr_done <= run_en && !accepting; // Core stalls while accepting
      maskable_return_op <= ret_req;
      stacked_imf <= stack_q[16];
      if (push_we)
      begin
        stack_q <= {stack_q[15:0], push_data};
      end
      if (sp_dec3)
      begin
        sp_q <= sp_q - 8'h03;
      end
    end
  end
endmodule

// >>> vectored_irq_latch_controller_bench.sv
// Self-checking bench for the interrupt controller and a CPU model.
// Assumes a 25 MHz clock and the offsets of the controller header.
`timescale 1ns/1ns
`include "virqc_map.svh"
module vectored_irq_latch_controller_bench
  import virqc_pkg::*;
;
  typedef struct packed
  {
    logic [4:0] src;
    logic [15:0] vec;
  } virqc_row_type;

  logic clk, rst, reg_wr, reg_rd, watchdog_event, addr_trap_event;
  logic undefined_op_irq, soft_irq, instr_done, enter_light_idle;
  logic maskable_return_op, stacked_imf, accepting, push_we, sp_dec3;
  logic vector_load, light_idle, resume, wdt_reset_req, trap_reset_req;
  logic master_irq_enable, run_en, ret_req;
  logic [3:0] reg_addr, ofs;
  logic [7:0] reg_wdata, reg_rdata, status_word, push_data, timebase_taps;
  logic [7:0] sp_q, sp_before, m;
  logic [4:0] ext_irq_n;
  logic [23:4] int_req, irq;
  logic [15:0] pc, vector;
  logic [23:0] stack_q;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int loads = 0;
  int i;
  virqc_row_type rows [11];

  virqc_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_irq_n(ext_irq_n), .int_req(int_req),
    .watchdog_event(watchdog_event), .addr_trap_event(addr_trap_event),
    .undefined_op_irq(undefined_op_irq), .soft_irq(soft_irq),
    .timebase_taps(timebase_taps), .instr_done(instr_done),
    .enter_light_idle(enter_light_idle),
    .maskable_return_op(maskable_return_op), .stacked_imf(stacked_imf),
    .status_word(status_word), .pc(pc), .accepting(accepting),
    .push_we(push_we), .push_data(push_data), .sp_dec3(sp_dec3),
    .vector_load(vector_load), .vector(vector), .light_idle(light_idle),
    .resume(resume), .wdt_reset_req(wdt_reset_req),
    .trap_reset_req(trap_reset_req), .master_irq_enable(master_irq_enable));

  virqc_cpu_model cpu (.clk(clk), .rst(rst), .run_en(run_en),
    .ret_req(ret_req), .accepting(accepting), .push_we(push_we),
    .push_data(push_data), .sp_dec3(sp_dec3), .instr_done(instr_done),
    .maskable_return_op(maskable_return_op), .stacked_imf(stacked_imf),
    .status_word(status_word), .pc(pc), .stack_q(stack_q), .sp_q(sp_q));

  // ==========================================================
  // Clock, hang guard and a count of vector loads
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    loads <= loads + int'(vector_load === 1'b1);
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  // ==========================================================
  // Bus, stimulus and compare tasks; all drives land on a rising edge
  task automatic chk(input string what, input logic [23:0] exp,
    input logic [23:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", 24'(exp), 24'(reg_rdata));
  endtask
  // Codes: 1 watchdog, 2 trap, 4 undefined, 8 soft, 16 idle, 32 return
  task automatic fire(input logic [5:0] c, input logic [23:4] q);
    @(posedge clk);
    {ret_req, enter_light_idle, soft_irq, undefined_op_irq,
      addr_trap_event, watchdog_event} <= c;
    int_req <= q;
    @(posedge clk);
    {ret_req, enter_light_idle, soft_irq, undefined_op_irq,
      addr_trap_event, watchdog_event} <= 6'h00;
    int_req <= 20'h0_0000;
  endtask
  task automatic run(input logic v);
    @(posedge clk);
    run_en <= v;
  endtask
  // Bounded wait for the vector load, then its value
  task automatic acc(input logic [15:0] exp);
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (vector_load !== 1'b1 && i < 40);
    chk("vector_load", 24'h1, 24'(vector_load));
    chk("vector", 24'(exp), 24'(vector));
  endtask
  task automatic tap_fall();
    @(posedge clk);
    timebase_taps <= 8'hFE;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {reg_wr, reg_rd, run_en} = 3'b000;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    fire_idle_init: {ret_req, enter_light_idle, soft_irq, undefined_op_irq,
      addr_trap_event, watchdog_event} = 6'h00;
    int_req = 20'h0_0000;
    ext_irq_n = 5'h1F;
    timebase_taps = 8'hFF;
    rows = '{'{5'h05, 16'hFFF4}, '{5'h07, 16'hFFF0}, '{5'h09, 16'hFFEC},
      '{5'h0A, 16'hFFEA}, '{5'h0B, 16'hFFE8}, '{5'h0C, 16'hFFE6},
      '{5'h0E, 16'hFFE2}, '{5'h0F, 16'hFFE0}, '{5'h10, 16'hFFBE},
      '{5'h11, 16'hFFBC}, '{5'h17, 16'hFFB0}};
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 10; a++)
    begin
      rdchk(4'(a), (a == 0) ? 8'h06 : (a == 7) ? 8'h01 : 8'h00);
    end
    // Table: one maskable source at a time, full acceptance and return
    foreach (rows[k])
    begin
      ofs = {2'b00, rows[k].src[4:3]} + 4'h1;
      m = 8'h01 << rows[k].src[2:0];
      irq = 20'h0_0000;
      irq[rows[k].src] = 1'b1;
      wr(`VIRQC_OFS_CTRL, 8'h07);
      wr(ofs, m);
      fire(6'h00, irq);
      rdchk(ofs + 4'h3, m);
      sp_before = sp_q;
      run(1'b1);
      acc(rows[k].vec);
      run(1'b0);
      chk("stack", 24'hA5_3C5A, stack_q);
      chk("sp", 24'(sp_before - 8'h03), 24'(sp_q));
      chk("imf", 24'h0, 24'(master_irq_enable));
      rdchk(ofs + 4'h3, 8'h00);
      fire(6'h20, 20'h0_0000);
      repeat (3) @(posedge clk);
      #1;
      chk("imf", 24'h1, 24'(master_irq_enable));
      wr(ofs, 8'h00);
    end
    // Master off, then own flag off: a pending latch is not taken
    wr(`VIRQC_OFS_CTRL, 8'h06);
    wr(`VIRQC_OFS_EF0, 8'h20);
    fire(6'h00, 20'h0_0002);
    i = loads;
    run(1'b1);
    repeat (20) @(posedge clk);
    // Flag off before master on, so no window opens between the writes
    wr(`VIRQC_OFS_EF0, 8'h00);
    wr(`VIRQC_OFS_CTRL, 8'h07);
    repeat (20) @(posedge clk);
    run(1'b0);
    chk("loads", 24'(i), 24'(loads));
    wr(`VIRQC_OFS_IL0, 8'hDF);
    rdchk(`VIRQC_OFS_IL0, 8'h00);
    // Selects at reset value: watchdog and trap ask for reset only
    wr(`VIRQC_OFS_CTRL, 8'h06);
    fire(6'h01, 20'h0_0000);
    #1;
    chk("wdt_reset_req", 24'h1, 24'(wdt_reset_req));
    fire(6'h02, 20'h0_0000);
    #1;
    chk("trap_reset_req", 24'h1, 24'(trap_reset_req));
    rdchk(`VIRQC_OFS_IL0, 8'h00);
    // All four non-maskables at once; latches 2 and 3 resist clearing
    wr(`VIRQC_OFS_CTRL, 8'h00);
    fire(6'h0F, 20'h0_0000);
    wr(`VIRQC_OFS_IL0, 8'h00);
    rdchk(`VIRQC_OFS_IL0, 8'h0C);
    run(1'b1);
    acc(16'hFFF8);
    acc(16'hFFFA);
    acc(16'hFFFC);
    acc(16'hFFFC);
    run(1'b0);
    // Two maskables together, then a non-maskable beside a maskable
    wr(`VIRQC_OFS_CTRL, 8'h07);
    wr(`VIRQC_OFS_EF0, 8'h20);
    wr(`VIRQC_OFS_EF1, 8'h04);
    fire(6'h00, 20'h0_0042);
    run(1'b1);
    acc(16'hFFF4);
    wr(`VIRQC_OFS_CTRL, 8'h07);
    acc(16'hFFEA);
    fire(6'h04, 20'h0_0002);
    acc(16'hFFFC);
    wr(`VIRQC_OFS_CTRL, 8'h07);
    acc(16'hFFF4);
    run(1'b0);
    // External pin 0 falls; needs the synchroniser to settle first
    wr(`VIRQC_OFS_EF0, 8'h10);
    wr(`VIRQC_OFS_CTRL, 8'h07);
    @(posedge clk);
    ext_irq_n <= 5'h1E;
    repeat (8) @(posedge clk);
    run(1'b1);
    acc(16'hFFF6);
    run(1'b0);
    ext_irq_n <= 5'h1F;
    // Light idle left by a tap fall with the product at zero
    wr(`VIRQC_OFS_EF0, 8'h00);
    wr(`VIRQC_OFS_CTRL, 8'h06);
    fire(6'h10, 20'h0_0000);
    #1;
    chk("light_idle", 24'h1, 24'(light_idle));
    tap_fall();
    i = 0;
    while (resume !== 1'b1 && i < 20)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("resume", 24'h1, 24'(resume));
    chk("light_idle", 24'h0, 24'(light_idle));
    @(posedge clk);
    timebase_taps <= 8'hFF;
    // Same with the product at one: the time-base vector is taken
    wr(`VIRQC_OFS_EF0, 8'h80);
    wr(`VIRQC_OFS_CTRL, 8'h0F);
    repeat (6) @(posedge clk);
    fire(6'h10, 20'h0_0000);
    tap_fall();
    acc(16'hFFF0);
    @(posedge clk);
    timebase_taps <= 8'hFF;
    wr(`VIRQC_OFS_CTRL, 8'h04);
    wr(`VIRQC_OFS_EF0, 8'h00);
    wr(`VIRQC_OFS_IL0, 8'h00);
    // Watchdog latch pending: idle entry is refused, watchdog served
    fire(6'h01, 20'h0_0000);
    fire(6'h10, 20'h0_0000);
    #1;
    chk("light_idle", 24'h0, 24'(light_idle));
    run(1'b1);
    acc(16'hFFF8);
    run(1'b0);
    end_of_test();
  end
endmodule
